// *** rtl/apdc_top.sv ***
// Purpose: auxiliary pll divider, power-down and word three configuration
// Assumes: word_valid pulses one cycle with a complete 24-bit word
// Notes:   serial shifting happens upstream; illegal host values are flagged only
//
// How it works
// (RULE1) host uses only listed ratios below 240 with large prescaler; never 47 or less
// (RULE2) aux divide 240..524287 accepted, split into 4-bit swallow and 15-bit upper
// (RULE3) powerdown bit 0 runs aux pll; 1 powers down and tristates pump
// (RULE4) auto powerup plus word_zero write clears powerdown bit and powers up
// (RULE5) chip enable low keeps aux pll down regardless of powerdown bit
// (RULE6) host writes aux reference divider between 3 and 4095
// (RULE7) aux reference divider taken from word three bits 15 to 4
// (RULE8) main pump gain code n selects current multiple n+1
// (RULE9) access bit 0 written as 1; next three pick words six..eight programmable
// (RULE10) word three fields load only on control code 0111
`timescale 1ns/1ps
module apdc_top (
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	input  wire logic [23:0] word_data,
	input  wire logic        word_valid,
	input  wire logic        chip_enable,
	input  wire logic        auto_powerup,
	input  wire logic        large_prescaler,
	output logic             aux_pll_run,
	output logic             aux_pump_tristate,
	output logic             aux_pll_powerdown,
	output logic [3:0]       aux_swallow_count,
	output logic [14:0]      aux_upper_count,
	output logic             aux_n_low,
	output logic [11:0]      aux_ref_div,
	output logic             aux_ref_div_low,
	output logic [3:0]       main_pump_gain,
	output logic [4:0]       main_pump_mult,
	output logic [2:0]       word_programmable,
	output logic             access_lsb_bad
);
	logic [3:0]  ctrl;
	logic        is_two;
	logic        is_three;
	logic        is_zero;
	logic        next_powerdown;
	logic [18:0] aux_n;
	logic [18:0] next_aux_n;
	logic [11:0] next_ref_div;
	logic [3:0]  next_gain;
	logic [3:0]  access;
	logic [3:0]  next_access;
	logic        run_c;
	logic        tri_c;
	logic        next_n_low;

	// word decode
	always_comb begin
		ctrl     = word_data[3:0];
		is_two   = word_valid && (ctrl == apdc_pkg::CODE_WORD_TWO);
		is_three = word_valid && (ctrl == apdc_pkg::CODE_WORD_THREE); // RULE10
		is_zero  = word_valid && !word_data[apdc_pkg::WORD_ZERO_BIT];
	end

	// power-down bit: word two writes it, auto powerup on word_zero clears it
	always_comb begin
		next_powerdown = aux_pll_powerdown;
		if (is_two) begin
			next_powerdown = word_data[apdc_pkg::PD_BIT]; // RULE3
		end
		if (is_zero && auto_powerup) begin
			next_powerdown = 1'b0; // RULE4
		end
	end

	// aux feedback divider, stored whole so every value up to the max is kept
	always_comb begin
		next_aux_n = aux_n;
		if (is_two) begin
			next_aux_n = word_data[apdc_pkg::AUX_N_LSB +: apdc_pkg::AUX_N_W]; // RULE2
		end
		// below 240 only a sparse set is legal; flag so software can notice
		next_n_low = large_prescaler && (next_aux_n < apdc_pkg::AUX_N_CONT_MIN); // RULE1
	end

	// word three fields
	always_comb begin
		next_ref_div = aux_ref_div;
		next_gain    = main_pump_gain;
		next_access  = access;
		if (is_three) begin // RULE10
			next_ref_div = word_data[apdc_pkg::REF_DIV_LSB +: apdc_pkg::REF_DIV_W]; // RULE7
			next_gain    = word_data[apdc_pkg::GAIN_LSB +: apdc_pkg::GAIN_W];
			next_access  = word_data[apdc_pkg::ACCESS_LSB +: apdc_pkg::ACCESS_W]; // RULE9
		end
	end

	// pin precedence resolved next to the stored bit, registered below
	apdc_power_ctl u_power (
		.chip_enable       (chip_enable),
		.aux_pll_powerdown (next_powerdown),
		.run               (run_c),
		.pump_tristate     (tri_c)
	);

	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			aux_pll_powerdown <= apdc_pkg::PD_RESET;
			aux_n             <= apdc_pkg::AUX_N_RESET;
			aux_ref_div       <= apdc_pkg::REF_DIV_RESET;
			main_pump_gain    <= apdc_pkg::GAIN_RESET;
			access            <= apdc_pkg::ACCESS_RESET;
			aux_pll_run       <= 1'b0;
			aux_pump_tristate <= 1'b1;
			aux_swallow_count <= apdc_pkg::AUX_N_RESET[3:0];
			aux_upper_count   <= apdc_pkg::AUX_N_RESET[18:4]; // must agree with the stored divider
			aux_n_low         <= 1'b0;
			aux_ref_div_low   <= 1'b0;
			main_pump_mult    <= 5'h01;
			word_programmable <= 3'h0;
			access_lsb_bad    <= 1'b0;
		end else begin
			aux_pll_powerdown <= next_powerdown;
			aux_n             <= next_aux_n;
			aux_ref_div       <= next_ref_div;
			main_pump_gain    <= next_gain;
			access            <= next_access;
			aux_pll_run       <= run_c;                  // RULE5
			aux_pump_tristate <= tri_c;                  // RULE3
			aux_swallow_count <= next_aux_n[3:0];        // RULE2
			aux_upper_count   <= next_aux_n[18:4];       // RULE2
			aux_n_low         <= next_n_low;
			aux_ref_div_low   <= next_ref_div < apdc_pkg::REF_DIV_MIN; // RULE6
			main_pump_mult    <= {1'b0, next_gain} + 5'h01; // RULE8
			word_programmable <= next_access[3:1];       // RULE9
			access_lsb_bad    <= !next_access[0];        // RULE9
		end
	end
endmodule

// *** rtl/apdc_pkg.sv ***
// Purpose: shared constants for the auxiliary pll divider configuration block
// Assumes: 24-bit configuration words arrive whole, one per valid pulse
// Notes:   control code sits in the low four bits of every word
package apdc_pkg;
	localparam int          WORD_W          = 24;
	localparam int          CTRL_W          = 4;
	// control codes of the words this block listens to
	localparam logic [3:0]  CODE_WORD_TWO   = 4'h5;
	localparam logic [3:0]  CODE_WORD_THREE = 4'h7;
	localparam int          WORD_ZERO_BIT   = 0;     // word_zero is any word with bit 0 low
	// word two layout
	localparam int          PD_BIT          = 23;
	localparam int          AUX_N_LSB       = 4;
	localparam int          AUX_N_W         = 19;
	localparam int          SWALLOW_W       = 4;
	localparam int          UPPER_W         = 15;
	// word three layout
	localparam int          REF_DIV_LSB     = 4;
	localparam int          REF_DIV_W       = 12;
	localparam int          GAIN_LSB        = 16;
	localparam int          GAIN_W          = 4;
	localparam int          ACCESS_LSB      = 20;
	localparam int          ACCESS_W        = 4;
	// limits
	localparam logic [18:0] AUX_N_CONT_MIN  = 19'h000f0; // 240
	localparam logic [11:0] REF_DIV_MIN     = 12'h003;
	// reset values
	localparam logic        PD_RESET        = 1'b1;
	localparam logic [18:0] AUX_N_RESET     = 19'h000f0;
	localparam logic [11:0] REF_DIV_RESET   = 12'h003;
	localparam logic [3:0]  GAIN_RESET      = 4'h0;
	localparam logic [3:0]  ACCESS_RESET    = 4'h1;
endpackage

// *** rtl/apdc_power_ctl.sv ***
// Purpose: resolves the auxiliary pll run state from pin and stored bit
// Assumes: inputs synchronous to sys_clk
// Notes:   pure combinational; the top registers the results
`timescale 1ns/1ps
module apdc_power_ctl (
	input  wire logic chip_enable,
	input  wire logic aux_pll_powerdown,
	output logic      run,
	output logic      pump_tristate
);
	// pin low wins over the stored bit
	always_comb begin
		run           = chip_enable && !aux_pll_powerdown; // RULE3 RULE5
		pump_tristate = !run;                              // RULE3
	end
endmodule

// *** test/apdc_checker.sv ***
// Purpose: port assertions on apdc_top. Assumes: one clock. Notes: bound at the foot
`timescale 1ns/1ps
module apdc_checker (
	input wire logic sys_clk, rst_n, word_valid, chip_enable, auto_powerup, aux_pll_run, aux_pll_powerdown,
	input wire logic aux_pump_tristate, aux_ref_div_low, access_lsb_bad,
	input wire logic [23:0] word_data,
	input wire logic [3:0]  aux_swallow_count, main_pump_gain,
	input wire logic [14:0] aux_upper_count,
	input wire logic [11:0] aux_ref_div,
	input wire logic [4:0]  main_pump_mult,
	input wire logic [2:0]  word_programmable
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// word decodes, codes as the package gives them
	wire w2 = word_valid && word_data[3:0] == 4'h5;
	wire w3 = word_valid && word_data[3:0] == 4'h7;
	AST_N: assert property (w2 |=> {aux_upper_count, aux_swallow_count} == $past(word_data[22:4])) else $error("n");
	AST_PD: assert property (w2 |=> aux_pll_powerdown == $past(word_data[23])) else $error("pd");
	AST_RUN: assert property ((chip_enable && !aux_pll_powerdown && !word_valid) [*2] |-> aux_pll_run) else $error("run");
	AST_CE: assert property (!chip_enable |=> !aux_pll_run) else $error("ce");
	AST_AUTO: assert property (auto_powerup && word_valid && !word_data[0] |=> !aux_pll_powerdown) else $error("auto");
	AST_REF: assert property (w3 |=> aux_ref_div == $past(word_data[15:4]) && word_programmable == $past(word_data[23:21]))
		else $error("ref");
	AST_GAIN: assert property (w3 |=> main_pump_gain == $past(word_data[19:16]) && main_pump_mult == {1'b0, $past(word_data[19:16])} + 5'h01)
		else $error("gain");
	AST_TRI: assert property (aux_pump_tristate == !aux_pll_run) else $error("tri");
	AST_REFLOW: assert property (w3 |=> aux_ref_div_low == ($past(word_data[15:4]) < 12'h003)) else $error("reflow");
	AST_LSB: assert property (w3 |=> access_lsb_bad == !$past(word_data[20])) else $error("lsb");
	AST_KEEP: assert property (word_valid && !w3 |=> $stable(aux_ref_div) && $stable(word_programmable)) else $error("keep");
	cover property (w3);
	cover property (!chip_enable ##1 chip_enable);
	cover property (auto_powerup && word_valid && !word_data[0]);
endmodule
bind apdc_top apdc_checker i_chk (.*);

// *** test/apdc_host.sv ***
// Purpose: host writing words. Assumes: falling-edge drive. Notes: one word per pulse
`timescale 1ns/1ps
module apdc_host (
	input wire logic    sys_clk,
	output logic [23:0] word_data,
	output logic        word_valid
);
	initial {word_data, word_valid} = 25'h0;
	// bus shows the inverse after the pulse so a stale word never looks fresh
	task automatic send(input logic [23:0] w);
		@(negedge sys_clk);
		{word_data, word_valid} = {w, 1'b1};
		@(negedge sys_clk);
		{word_data, word_valid} = {~w, 1'b0};
		@(negedge sys_clk);
	endtask
endmodule

// *** test/apdc_tb.sv ***
// Purpose: self-check of apdc_top. Assumes: 100 MHz. Notes: words come from the host model
`timescale 1ns/1ps
module apdc_tb;
	logic sys_clk, rst_n, chip_enable, auto_powerup, large_prescaler, word_valid;
	logic aux_pll_run, aux_pump_tristate, aux_pll_powerdown, aux_n_low, aux_ref_div_low, access_lsb_bad;
	logic [23:0] word_data;
	logic [3:0]  aux_swallow_count, main_pump_gain;
	logic [14:0] aux_upper_count;
	logic [11:0] aux_ref_div;
	logic [4:0]  main_pump_mult;
	logic [2:0]  word_programmable;
	int          fails, n_compared;
	// word sent, then expected ref_div, gain, mult, programmable
	logic [47:0] rows [5] = '{48'h3a0127_012a59, 48'hff0037_003f87, 48'h10fff7_fff008, 48'h200017_001009,
	                          48'h5a5ab3_001009};
	wire [22:0]  pw = {aux_pll_run, aux_pump_tristate, aux_pll_powerdown, aux_upper_count, aux_swallow_count, aux_n_low};
	apdc_top i_dut (.*);
	apdc_host i_host (.*);
	task automatic chk(input string nm, input logic [23:0] e, g);
		n_compared++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic results;
		$display("fails %0d compared %0d", fails, n_compared);
		if (fails == 0 && n_compared > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// reset held twelve cycles, defaults checked right after release
	task automatic rst_chk;
		rst_n = 1'b0;
		repeat (12) @(negedge sys_clk);
		rst_n = 1'b1;
		chk("reset", {3'b011, 12'h003, 4'h0, 5'h01}, {pw[22:20], aux_ref_div, main_pump_gain, main_pump_mult});
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// whole run is under a hundred cycles
	initial begin
		#5000;
		fails++;
		results;
	end
	initial begin
		{chip_enable, auto_powerup, large_prescaler} = 3'b101;
		rst_chk;
		@(negedge sys_clk);
		chk("rstn", {3'b011, 19'h000f0, 1'b0}, pw);
		foreach (rows[i]) begin
			i_host.send(rows[i][47:24]);
			chk("w3", rows[i][23:0], {aux_ref_div, main_pump_gain, main_pump_mult, word_programmable});
		end
		chk("flags", 2'b11, {aux_ref_div_low, access_lsb_bad});
		i_host.send(24'h7ffff5);
		chk("nmax", {3'b100, 19'h7ffff, 1'b0}, pw);
		i_host.send(24'h800ee5);
		chk("n238", {3'b011, 19'h000ee, 1'b1}, pw);
		auto_powerup = 1'b1;
		i_host.send(24'h000000);
		chk("auto", {3'b100, 19'h000ee, 1'b1}, pw);
		chip_enable = 1'b0;
		repeat (2) @(negedge sys_clk);
		chk("ce", {3'b010, 19'h000ee, 1'b1}, pw);
		rst_chk;
		results;
	end
endmodule
